// File: hw/buck_regs_pkg.sv
// Package of register offsets, field layouts, reset values and timing counts
package buck_regs_pkg;
	localparam logic [7:0] OFS_REGULATOR_STATUS = 8'h11;
	localparam logic [7:0] OFS_VOLTAGE_CHANGE_CONTROL = 8'h20;
	localparam logic [7:0] OFS_BUCK1_TARGET_ONE = 8'h23;
	localparam logic [7:0] OFS_BUCK1_TARGET_TWO = 8'h24;
	localparam logic [7:0] OFS_BUCK1_RAMP_CONTROL = 8'h25;
	// Status bit positions
	localparam int POS_ALL_BUCKS = 7;
	localparam int POS_ALL_LINEAR = 6;
	localparam int POS_LINEAR2 = 5;
	localparam int POS_LINEAR1 = 4;
	localparam int POS_BUCK2 = 2;
	localparam int POS_BUCK1 = 0;
	// Voltage change control bit positions
	localparam int POS_B2_SELECT = 5;
	localparam int POS_B2_GO = 4;
	localparam int POS_B1_SELECT = 1;
	localparam int POS_B1_GO = 0;
	localparam logic [7:0] VCC_MASK = 8'h33;
	// Reset values
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_VCC = 8'h00;
	localparam logic [2:0] RST_TARGET_RSVD = 3'h0;
	localparam logic [2:0] RST_RAMP_RSVD = 3'h2;
	localparam logic RST_RAMP_TOP = 1'h0;
	localparam logic [3:0] RST_RAMP_RATE = 4'h8;
	// Code limits
	localparam logic [4:0] CODE_EXT_CTRL = 5'h00;
	localparam logic [4:0] CODE_MAX = 5'h19;
	localparam logic [3:0] RATE_INSTANT = 4'h0;
	localparam logic [3:0] RATE_MAX = 4'hA;
	// Buck1 code step is 50 mV; one step per (50 / rate) us
	localparam int STEP_MV = 50;
	localparam int CLK_MHZ = 100;
	localparam int STEP_CYCLES_PER_RATE = STEP_MV * CLK_MHZ;
endpackage

// File: hw/reg_write_port.sv
// Byte-level register write port: offset byte then data byte
`timescale 1ns/10ps
`default_nettype none
module reg_write_port (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_i,
	input wire logic frame_start_i,
	output logic wr_en_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o
);
	logic have_addr_q;
	logic have_addr_d;
	logic [7:0] addr_q;
	logic [7:0] addr_d;
	logic wr_q;
	logic wr_d;
	logic [7:0] data_q;
	logic [7:0] data_d;

	// First byte after a frame start names the offset; later bytes write
	always_comb begin
		have_addr_d = have_addr_q;
		addr_d = addr_q;
		data_d = data_q;
		wr_d = 1'b0;
		if (frame_start_i) begin
			have_addr_d = 1'b0;
		end else if (byte_valid_i) begin
			if (!have_addr_q) begin
				addr_d = byte_i;
				have_addr_d = 1'b1;
			end else begin
				data_d = byte_i;
				wr_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			have_addr_q <= 1'b0;
			addr_q <= 8'h00;
			data_q <= 8'h00;
			wr_q <= 1'b0;
		end else begin
			have_addr_q <= have_addr_d;
			addr_q <= addr_d;
			data_q <= data_d;
			wr_q <= wr_d;
		end
	end

	assign wr_en_o = wr_q;
	assign addr_o = addr_q;
	assign wdata_o = data_q;
endmodule
`default_nettype wire

// File: hw/ramp_engine.sv
// Moves a 5-bit setpoint toward a target code at a programmed rate
`timescale 1ns/10ps
`default_nettype none
module ramp_engine #(
	parameter int STEP_UNIT = buck_regs_pkg::STEP_CYCLES_PER_RATE
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic [4:0] target_i,
	input wire logic [3:0] rate_i,
	output logic [4:0] setpoint_o,
	output logic busy_o
);
	logic [4:0] sp_q;
	logic [4:0] sp_d;
	logic [19:0] cnt_q;
	logic [19:0] cnt_d;
	logic [3:0] rate_eff;
	logic [19:0] period;

	// Codes above the top rate behave as the top rate
	always_comb begin
		rate_eff = (rate_i > buck_regs_pkg::RATE_MAX) ?
			buck_regs_pkg::RATE_MAX : rate_i;
		period = (rate_eff == 4'h0) ? 20'h00001 :
			20'(STEP_UNIT / int'(rate_eff));
	end

	always_comb begin
		sp_d = sp_q;
		cnt_d = cnt_q;
		if (go_i && sp_q != target_i) begin
			if (rate_i == buck_regs_pkg::RATE_INSTANT) begin
				sp_d = target_i;
				cnt_d = 20'h00000;
			end else if (cnt_q + 20'h00001 >= period) begin
				sp_d = (sp_q < target_i) ? sp_q + 5'h01 : sp_q - 5'h01;
				cnt_d = 20'h00000;
			end else begin
				cnt_d = cnt_q + 20'h00001;
			end
		end else begin
			cnt_d = 20'h00000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sp_q <= 5'h00;
			cnt_q <= 20'h00000;
		end else begin
			sp_q <= sp_d;
			cnt_q <= cnt_d;
		end
	end

	assign setpoint_o = sp_q;
	assign busy_o = go_i && (sp_q != target_i);
endmodule
`default_nettype wire

// File: hw/buck_voltage_select_regs.sv
// Buck voltage select and regulator status register bank
// ----------------------------------------------------------------
// Operation
// - Status reports per-regulator valid flags at bits 5,4,2,0 and all-bucks/all-linear flags at bits 7,6.
// - Status is read-only and resets to all zeros, reserved bits too.
// - Control bits 1 and 5 pick target one or two for buck1 and buck2.
// - Control bits 0 and 4 hold or ramp each buck; all reset to zero.
// - Buck1 target one bits 4:0: code 01 is 0.80 V in 0.05 V steps to 19.
// - Buck1 codes 1A to 1F saturate to the 2.00 V code.
// - Buck1 code 00 selects external voltage control.
// - Buck1 target two uses the same field; bits 7:5 reset to zero.
// - Buck1 ramp rate code 0 is instant, 1 to A are mV/us, B to F as A.
// - Ramp control resets to bit7 0, bits 6:4 010, rate 1000.
// - Buck2 codes map 01 to 1.0 V, 0E to 2.4 V, 19 to 3.5 V.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module buck_voltage_select_regs #(
	parameter logic [4:0] B1_CODE_ONE_DEFAULT = 5'h0D,
	parameter logic [4:0] B1_CODE_TWO_DEFAULT = 5'h0D,
	parameter int STEP_UNIT = buck_regs_pkg::STEP_CYCLES_PER_RATE
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic frame_start_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_i,
	input wire logic [7:0] rd_addr_i,
	input wire logic buck1_ok_i,
	input wire logic buck2_ok_i,
	input wire logic linear1_ok_i,
	input wire logic linear2_ok_i,
	output logic [7:0] rd_data_o,
	output logic [4:0] buck1_setpoint_o,
	output logic buck1_ext_ctrl_o,
	output logic buck1_ramp_busy_o,
	output logic buck2_go_o,
	output logic buck2_select_o
);
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] vcc_q;
	logic [7:0] vcc_d;
	logic [7:0] tv1_q;
	logic [7:0] tv1_d;
	logic [7:0] tv2_q;
	logic [7:0] tv2_d;
	logic [7:0] rc_q;
	logic [7:0] rc_d;
	logic [7:0] rd_q;
	logic [7:0] rd_d;
	logic [4:0] sp_q;
	logic [4:0] sp_d;
	logic ext_q;
	logic ext_d;
	logic busy_q;
	logic busy_d;
	logic [4:0] sel_code;
	logic [4:0] sat_code;
	logic [4:0] ramp_sp;
	logic ramp_busy;
	logic ramp_go;

	// ----------------------------------------------------------------
	// Host write path
	// ----------------------------------------------------------------
	reg_write_port u_port (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.byte_valid_i(byte_valid_i),
		.byte_i(byte_i),
		.frame_start_i(frame_start_i),
		.wr_en_o(wr_en),
		.addr_o(wr_addr),
		.wdata_o(wr_data)
	);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	always_comb begin
		status_d = 8'h00;
		status_d[buck_regs_pkg::POS_BUCK1] = buck1_ok_i;
		status_d[buck_regs_pkg::POS_BUCK2] = buck2_ok_i;
		status_d[buck_regs_pkg::POS_LINEAR1] = linear1_ok_i;
		status_d[buck_regs_pkg::POS_LINEAR2] = linear2_ok_i;
		status_d[buck_regs_pkg::POS_ALL_BUCKS] = buck1_ok_i & buck2_ok_i;
		status_d[buck_regs_pkg::POS_ALL_LINEAR] =
			linear1_ok_i & linear2_ok_i;
		vcc_d = vcc_q;
		tv1_d = tv1_q;
		tv2_d = tv2_q;
		rc_d = rc_q;
		// Status has no write path at all
		if (wr_en) begin
			case (wr_addr)
				buck_regs_pkg::OFS_VOLTAGE_CHANGE_CONTROL: begin
					vcc_d = wr_data & buck_regs_pkg::VCC_MASK;
				end
				buck_regs_pkg::OFS_BUCK1_TARGET_ONE: begin
					tv1_d = {3'h0, wr_data[4:0]};
				end
				buck_regs_pkg::OFS_BUCK1_TARGET_TWO: begin
					tv2_d = {3'h0, wr_data[4:0]};
				end
				buck_regs_pkg::OFS_BUCK1_RAMP_CONTROL: begin
					// Reserved bits keep their reset pattern
					rc_d = {rc_q[7:4], wr_data[3:0]};
				end
				default: begin
					vcc_d = vcc_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= buck_regs_pkg::RST_STATUS;
			vcc_q <= buck_regs_pkg::RST_VCC;
			tv1_q <= {buck_regs_pkg::RST_TARGET_RSVD, B1_CODE_ONE_DEFAULT};
			tv2_q <= {buck_regs_pkg::RST_TARGET_RSVD, B1_CODE_TWO_DEFAULT};
			rc_q <= {buck_regs_pkg::RST_RAMP_TOP, buck_regs_pkg::RST_RAMP_RSVD,
				buck_regs_pkg::RST_RAMP_RATE};
		end else begin
			status_q <= status_d;
			vcc_q <= vcc_d;
			tv1_q <= tv1_d;
			tv2_q <= tv2_d;
			rc_q <= rc_d;
		end
	end

	// ----------------------------------------------------------------
	// Target selection and ramp
	// ----------------------------------------------------------------
	always_comb begin
		sel_code = vcc_q[buck_regs_pkg::POS_B1_SELECT] ?
			tv2_q[4:0] : tv1_q[4:0];
		// Saturate so the ramp never walks past the top code
		sat_code = (sel_code > buck_regs_pkg::CODE_MAX) ?
			buck_regs_pkg::CODE_MAX : sel_code;
		// Code 00 hands the output to external control, so the ramp waits
		ramp_go = vcc_q[buck_regs_pkg::POS_B1_GO] &&
			(sel_code != buck_regs_pkg::CODE_EXT_CTRL);
	end

	ramp_engine #(
		.STEP_UNIT(STEP_UNIT)
	) u_ramp (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.go_i(ramp_go),
		.target_i(sat_code),
		.rate_i(rc_q[3:0]),
		.setpoint_o(ramp_sp),
		.busy_o(ramp_busy)
	);

	// ----------------------------------------------------------------
	// Read path and outputs
	// ----------------------------------------------------------------
	always_comb begin
		case (rd_addr_i)
			buck_regs_pkg::OFS_REGULATOR_STATUS: rd_d = status_q;
			buck_regs_pkg::OFS_VOLTAGE_CHANGE_CONTROL: rd_d = vcc_q;
			buck_regs_pkg::OFS_BUCK1_TARGET_ONE: rd_d = tv1_q;
			buck_regs_pkg::OFS_BUCK1_TARGET_TWO: rd_d = tv2_q;
			buck_regs_pkg::OFS_BUCK1_RAMP_CONTROL: rd_d = rc_q;
			default: rd_d = 8'h00;
		endcase
		sp_d = ramp_sp;
		// External control follows the code the ramp was told to reach
		ext_d = vcc_q[buck_regs_pkg::POS_B1_GO] &&
			(sel_code == buck_regs_pkg::CODE_EXT_CTRL);
		busy_d = ramp_busy;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_q <= 8'h00;
			sp_q <= 5'h00;
			ext_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			rd_q <= rd_d;
			sp_q <= sp_d;
			ext_q <= ext_d;
			busy_q <= busy_d;
		end
	end

	assign rd_data_o = rd_q;
	assign buck1_setpoint_o = sp_q;
	assign buck1_ext_ctrl_o = ext_q;
	assign buck1_ramp_busy_o = busy_q;
	// Buck2 only takes its go and select bits from this bank
	assign buck2_go_o = vcc_q[buck_regs_pkg::POS_B2_GO];
	assign buck2_select_o = vcc_q[buck_regs_pkg::POS_B2_SELECT];

	// ----------------------------------------------------------------
	// Buck2 code map
	// ----------------------------------------------------------------
	// Tenths of a volt per buck2 code; the 2.3 V step is skipped, which
	// the buck2 converter's decode has to reproduce
	function automatic logic [5:0] buck2_tenths(input logic [4:0] code);
		logic [5:0] t;
		t = 6'(code) + 6'h09;
		if (code > 5'h0D) begin
			t = t + 6'h01;
		end
		if (code > buck_regs_pkg::CODE_MAX) begin
			t = 6'h23;
		end
		return t;
	endfunction

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_status_and: assert property (@(posedge clk_i)
		disable iff (rst_i) !$past(rst_i) |->
		status_q[7] == ($past(buck1_ok_i) & $past(buck2_ok_i)) &&
		status_q[6] == ($past(linear1_ok_i) & $past(linear2_ok_i)))
		else $error("aggregate flag wrong");
	a_status_bits: assert property (@(posedge clk_i)
		disable iff (rst_i) !$past(rst_i) |->
		status_q[0] == $past(buck1_ok_i) &&
		status_q[2] == $past(buck2_ok_i) &&
		status_q[4] == $past(linear1_ok_i) &&
		status_q[5] == $past(linear2_ok_i))
		else $error("status flag wrong");
	a_status_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
		status_q[3] == 1'b0 && status_q[1] == 1'b0)
		else $error("status reserved bit set");
	a_vcc_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_en && wr_addr == 8'h20 |=> vcc_q == ($past(wr_data) & 8'h33))
		else $error("control write lost");
	a_tv2_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
		tv2_q[7:5] == 3'h0)
		else $error("target two reserved bits set");
	a_rc_reset: assert property (@(posedge clk_i)
		rst_i |=> rc_q == 8'h28)
		else $error("ramp control reset wrong");
	a_rc_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
		rc_q[7:4] == 4'h2)
		else $error("ramp reserved bits changed");
	a_sat_code: assert property (@(posedge clk_i) disable iff (rst_i)
		sel_code > 5'h19 |-> sat_code == 5'h19)
		else $error("code not saturated");
	a_instant_ramp: assert property (@(posedge clk_i) disable iff (rst_i)
		vcc_q[0] && rc_q[3:0] == 4'h0 && sat_code != 5'h00 &&
		$stable(sat_code) && $stable(vcc_q)
		|=> ##1 buck1_setpoint_o == $past(sat_code, 2))
		else $error("instant ramp slow");
	a_ramp_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!vcc_q[0] && !$past(vcc_q[0]) |=> $stable(sp_q))
		else $error("setpoint moved while held");
	a_ext_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
		vcc_q[0] && sel_code == 5'h00 |=> buck1_ext_ctrl_o)
		else $error("external control missed");
	a_ext_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		vcc_q[0] && sel_code == 5'h00 && $past(vcc_q[0]) &&
		$past(sel_code) == 5'h00 |=> $stable(sp_q))
		else $error("setpoint moved under external control");
	a_vcc_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
		(vcc_q & ~buck_regs_pkg::VCC_MASK) == 8'h00)
		else $error("control reserved bit set");
	a_tv1_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
		tv1_q[7:5] == 3'h0)
		else $error("target one reserved bits set");
	a_rd_status: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_addr_i == buck_regs_pkg::OFS_REGULATOR_STATUS |=>
		rd_data_o == $past(status_q))
		else $error("status read wrong");
	// A programmed rate may never skip codes, whatever the target does
	a_ramp_step: assert property (@(posedge clk_i) disable iff (rst_i)
		rc_q[3:0] != 4'h0 |=> ramp_sp == $past(ramp_sp) ||
		ramp_sp == $past(ramp_sp) + 5'h01 ||
		ramp_sp == $past(ramp_sp) - 5'h01)
		else $error("ramp skipped a code");
	a_b2_code_map: assert property (@(posedge clk_i) disable iff (rst_i)
		buck2_tenths(5'h01) == 6'h0A && buck2_tenths(5'h0E) == 6'h18 &&
		buck2_tenths(5'h19) == 6'h23 && buck2_tenths(5'h1F) == 6'h23)
		else $error("buck2 code map wrong");
	c_ramp_up: cover property (@(posedge clk_i) disable iff (rst_i)
		vcc_q[0] && $changed(sp_q));
	c_sel_two: cover property (@(posedge clk_i) disable iff (rst_i)
		vcc_q[1] && vcc_q[0]);
	c_all_ok: cover property (@(posedge clk_i) disable iff (rst_i)
		status_q[7] && status_q[6]);
	c_ext_ctrl: cover property (@(posedge clk_i) disable iff (rst_i)
		buck1_ext_ctrl_o);
	c_instant: cover property (@(posedge clk_i) disable iff (rst_i)
		vcc_q[0] && rc_q[3:0] == 4'h0 && $changed(sp_q));
endmodule
`default_nettype wire

// File: verif/host_model.sv
// Host controller model that sends register write frames as bytes
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic clk_i,
	output logic frame_start_o,
	output logic byte_valid_o,
	output logic [7:0] byte_o
);
	initial begin
		frame_start_o = 1'b0;
		byte_valid_o = 1'b0;
		byte_o = 8'hA5;
	end
	// Frame start, then the offset byte, then one data byte
	task automatic write_reg(input logic [7:0] ofs, input logic [7:0] dat);
		@(posedge clk_i);
		frame_start_o <= 1'b1;
		@(posedge clk_i);
		frame_start_o <= 1'b0;
		byte_valid_o <= 1'b1;
		byte_o <= ofs;
		@(posedge clk_i);
		byte_o <= dat;
		@(posedge clk_i);
		byte_valid_o <= 1'b0;
		// Idle bytes show the inverse so stale data never looks fresh
		byte_o <= ~dat;
		repeat (3) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the buck voltage select register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int UNIT = 20;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic frame_start;
	logic byte_valid;
	logic [7:0] byte_d;
	logic [7:0] rd_addr = 8'h00;
	logic [3:0] ok = 4'h0;
	logic [7:0] rd_data;
	logic [4:0] setpoint;
	logic ext_ctrl;
	logic busy;
	logic b2_go;
	logic b2_sel;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	always #5 clk_i = ~clk_i;
	host_model host_model_i (.clk_i(clk_i), .frame_start_o(frame_start),
		.byte_valid_o(byte_valid), .byte_o(byte_d));
	buck_voltage_select_regs #(.B1_CODE_ONE_DEFAULT(5'h0D),
		.B1_CODE_TWO_DEFAULT(5'h0D), .STEP_UNIT(UNIT))
		buck_voltage_select_regs_i (.clk_i(clk_i), .rst_i(rst_i),
		.frame_start_i(frame_start), .byte_valid_i(byte_valid),
		.byte_i(byte_d), .rd_addr_i(rd_addr), .buck1_ok_i(ok[0]),
		.buck2_ok_i(ok[1]), .linear1_ok_i(ok[2]), .linear2_ok_i(ok[3]),
		.rd_data_o(rd_data), .buck1_setpoint_o(setpoint),
		.buck1_ext_ctrl_o(ext_ctrl), .buck1_ramp_busy_o(busy),
		.buck2_go_o(b2_go), .buck2_select_o(b2_sel));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task close_out;
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Status needs an extra edge to be sampled, so every read waits three
	task chk_reg(input logic [7:0] ofs, input logic [7:0] exp);
		@(posedge clk_i);
		rd_addr <= ofs;
		repeat (3) @(posedge clk_i);
		#1 cmp(rd_data, exp);
	endtask
	task wr(input logic [7:0] ofs, input logic [7:0] dat);
		host_model_i.write_reg(ofs, dat);
		#1;
	endtask
	task wait_sp(input logic [4:0] exp);
		n = 0;
		while (setpoint !== exp && n < 1000) begin
			@(posedge clk_i);
			#1 n++;
		end
	endtask
	function automatic logic [7:0] in_range(int v, int lo, int hi);
		return {7'h00, v >= lo && v <= hi};
	endfunction
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		chk_reg(8'h11, 8'h00);
		chk_reg(8'h20, 8'h00);
		chk_reg(8'h23, 8'h0D);
		chk_reg(8'h24, 8'h0D);
		chk_reg(8'h25, 8'h28);
		chk_reg(8'h30, 8'h00);
	endtask
	task t_status;
		logic [7:0] e;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_i);
			ok <= i[3:0];
			e = {i[0] & i[1], i[2] & i[3], i[3], i[2], 1'b0, i[1], 1'b0, i[0]};
			chk_reg(8'h11, e);
		end
		wr(8'h11, 8'h0A);
		chk_reg(8'h11, 8'hF5);
	endtask
	task t_fields;
		wr(8'h20, 8'hFF);
		chk_reg(8'h20, 8'h33);
		cmp({6'h00, b2_sel, b2_go}, 8'h03);
		wr(8'h20, 8'h00);
		cmp({6'h00, b2_sel, b2_go}, 8'h00);
		wr(8'h23, 8'hFF);
		chk_reg(8'h23, 8'h1F);
		wr(8'h24, 8'hE0);
		chk_reg(8'h24, 8'h00);
		wr(8'h25, 8'hFF);
		chk_reg(8'h25, 8'h2F);
	endtask
	task t_instant;
		wr(8'h25, 8'h00);
		wr(8'h23, 8'h01);
		wr(8'h20, 8'h01);
		wait_sp(5'h01);
		cmp(in_range(n, 0, 2), 8'h01);
		wr(8'h24, 8'h1F);
		wr(8'h20, 8'h03);
		wait_sp(5'h19);
		cmp({3'h0, setpoint}, 8'h19);
		chk_reg(8'h24, 8'h1F);
	endtask
	// Steps take UNIT/rate cycles; codes above A must act as A
	task t_ramp;
		wr(8'h25, 8'h0F);
		wr(8'h23, 8'h01);
		wr(8'h20, 8'h01);
		cmp({7'h00, busy}, 8'h01);
		wait_sp(5'h01);
		cmp(in_range(n, 38, 50), 8'h01);
		wr(8'h25, 8'h05);
		wr(8'h23, 8'h19);
		wait_sp(5'h19);
		cmp(in_range(n, 84, 98), 8'h01);
		cmp({7'h00, busy}, 8'h00);
	endtask
	task t_hold_ext;
		wr(8'h20, 8'h00);
		wr(8'h23, 8'h05);
		repeat (20) @(posedge clk_i);
		#1 cmp({3'h0, setpoint}, 8'h19);
		wr(8'h23, 8'h00);
		wr(8'h20, 8'h01);
		cmp({2'h0, ext_ctrl, setpoint}, 8'h39);
		repeat (20) @(posedge clk_i);
		#1 cmp({2'h0, busy, setpoint}, 8'h19);
	endtask
	task t_rereset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		chk_reg(8'h25, 8'h28);
		cmp({2'h0, ext_ctrl, setpoint}, 8'h00);
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_status();
		t_fields();
		t_instant();
		t_ramp();
		t_hold_ext();
		t_rereset();
		close_out();
	end
endmodule
`default_nettype wire
